// ==== spisf_params.svh ====
`ifndef SPISF_PARAMS_SVH
`define SPISF_PARAMS_SVH
`define SPISF_IDX_CTRL 10'h010
`define SPISF_IDX_STAT 10'h011
`define SPISF_IDX_DATA 10'h012
`define SPISF_CT_RXIE 7
`define SPISF_CT_MSTR 5
`define SPISF_CT_CPOL 4
`define SPISF_CT_EN 1
`define SPISF_CT_TXIE 0
`define SPISF_ST_RXF 7
`define SPISF_ST_ERROR_IRQ_ENABLE 6
`define SPISF_ST_OVR 5
`define SPISF_ST_MODE_FAULT_FLAG 4
`define SPISF_ST_TXE 3
`define SPISF_ST_FDEN 2
`define SPISF_ST_RATEH 1
`define SPISF_ST_RATEL 0
`define SPISF_RST_MASTER 1'b1
`define SPISF_RST_TXE 1'b1
`define SPISF_BD0 8'h02
`define SPISF_BD1 8'h08
`define SPISF_BD2 8'h20
`define SPISF_BD3 8'h80
`define SPISF_LAST_BIT 3'h7
`endif

// ==== spisf_pkg.sv ====
package spisf_pkg;
    typedef struct packed {
        logic rx_ie;
        logic master;
        logic cpol;
        logic enable;
        logic tx_ie;
        logic err_ie;
        logic fault_en;
        logic [1:0] rate;
        logic rx_full;
        logic ovr;
        logic mode_fault_flag;
        logic tx_empty;
        logic arm_ovr;
        logic arm_mode_fault_flag;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic [7:0] shreg;
        logic rx_bit;
        logic [2:0] bitcnt;
        logic busy;
        logic [7:0] divcnt;
        logic sclk_int;
        logic sclk_prev;
        logic ss_prev;
        logic dp_write;
        logic [9:0] dp_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic mosi;
        logic pins_oe;
        logic miso_oe;
        logic rx_irq;
        logic err_irq;
        logic tx_irq;
        logic ss_owned;
    } spisf_state_t;
endpackage

// ==== spisf_top.sv ====
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "spisf_params.svh"
module spisf_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic ss_owned,
    output logic rx_irq,
    output logic err_irq,
    output logic tx_irq
);
    spisf_pkg::spisf_state_t s;
    spisf_pkg::spisf_state_t next_s;
    logic addr_ok;
    logic stat_rd;
    logic data_rd;
    logic data_wr;
    logic [9:0] idx;
    logic [7:0] ctrl_v;
    logic [7:0] stat_v;
    logic [7:0] bd;
    logic pulse;
    logic lead;
    logic trail;
    logic done;
    logic ss_rise;
    logic slave_sel;
    logic [7:0] rx_word;

    always_comb begin
        next_s = s;
        idx = haddr[11:2];
        addr_ok = hsel & hready & htrans[1];
        stat_rd = addr_ok & ~hwrite & (idx == `SPISF_IDX_STAT);
        data_rd = addr_ok & ~hwrite & (idx == `SPISF_IDX_DATA);
        data_wr = s.dp_write & (s.dp_idx == `SPISF_IDX_DATA);
        pulse = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        done = 1'b0;
        ss_rise = ss_n_i & ~s.ss_prev;
        slave_sel = s.enable & ~s.master & ~ss_n_i;
        rx_word = {s.shreg[6:0], s.rx_bit};
        ctrl_v = 8'h00;
        ctrl_v[`SPISF_CT_RXIE] = s.rx_ie;
        ctrl_v[`SPISF_CT_MSTR] = s.master;
        ctrl_v[`SPISF_CT_CPOL] = s.cpol;
        ctrl_v[`SPISF_CT_EN] = s.enable;
        ctrl_v[`SPISF_CT_TXIE] = s.tx_ie;
        stat_v = 8'h00;
        stat_v[`SPISF_ST_RXF] = s.rx_full;
        stat_v[`SPISF_ST_ERROR_IRQ_ENABLE] = s.err_ie;
        stat_v[`SPISF_ST_OVR] = s.ovr;
        stat_v[`SPISF_ST_MODE_FAULT_FLAG] = s.mode_fault_flag;
        stat_v[`SPISF_ST_TXE] = s.tx_empty;
        stat_v[`SPISF_ST_FDEN] = s.fault_en;
        stat_v[`SPISF_ST_RATEH] = s.rate[1];
        stat_v[`SPISF_ST_RATEL] = s.rate[0];
        unique case (s.rate)
            2'b00: bd = `SPISF_BD0;
            2'b01: bd = `SPISF_BD1;
            2'b10: bd = `SPISF_BD2;
            2'b11: bd = `SPISF_BD3;
        endcase

        // Read data is latched in the address phase so it leaves a flop in the data phase
        next_s.dp_write = addr_ok & hwrite;
        next_s.dp_idx = idx;
        next_s.hrdata = 32'h0;
        if (addr_ok & ~hwrite) begin
            if (idx == `SPISF_IDX_CTRL) begin
                next_s.hrdata[7:0] = ctrl_v;
            end else if (idx == `SPISF_IDX_STAT) begin
                next_s.hrdata[7:0] = stat_v;
            end else if (idx == `SPISF_IDX_DATA) begin
                next_s.hrdata[7:0] = s.rxd;
            end
        end
        next_s.hreadyout = 1'b1;

        next_s.ss_prev = ss_n_i;
        next_s.sclk_prev = sclk_i;
        if (s.enable & s.master) begin
            if (s.busy) begin
                // Half-period of the serial clock is the divisor, full period twice it
                if (s.divcnt == bd - 8'h01) begin
                    next_s.divcnt = 8'h00;
                    pulse = 1'b1;
                end else begin
                    next_s.divcnt = s.divcnt + 8'h01;
                end
            end
            if (pulse) begin
                next_s.sclk_int = ~s.sclk_int;
                lead = (s.sclk_int == s.cpol);
                trail = ~lead;
            end
        end else begin
            // Deselected slave sees no edges at all, even mid-byte
            lead = slave_sel & (sclk_i != s.cpol) & (s.sclk_prev == s.cpol);
            trail = slave_sel & (sclk_i == s.cpol) & (s.sclk_prev != s.cpol);
        end
        if (lead) begin
            next_s.rx_bit = s.master ? miso_i : mosi_i;
            next_s.busy = 1'b1;
        end
        if (trail & s.busy) begin
            next_s.shreg = rx_word;
            next_s.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == `SPISF_LAST_BIT) begin
                done = 1'b1;
                next_s.busy = 1'b0;
            end
        end
        if (~s.enable) begin
            next_s.busy = 1'b0;
            next_s.bitcnt = 3'h0;
        end
        if (~next_s.busy) begin
            next_s.sclk_int = s.cpol;
            next_s.divcnt = 8'h00;
        end

        // A slave that has seen its first edge keeps its byte until the end
        if (s.enable & ~s.busy & ~done & ~s.tx_empty) begin
            next_s.shreg = s.txd;
            next_s.bitcnt = 3'h0;
            next_s.tx_empty = 1'b1;
            if (s.master) begin
                next_s.busy = 1'b1;
            end
        end

        // Arming records what the status read really showed
        if (stat_rd) begin
            next_s.arm_ovr = s.ovr;
            next_s.arm_mode_fault_flag = s.mode_fault_flag;
        end
        if (data_rd) begin
            next_s.rx_full = 1'b0;
            if (s.arm_ovr) begin
                next_s.ovr = 1'b0;
                next_s.arm_ovr = 1'b0;
            end
        end
        if (data_wr) begin
            next_s.txd = hwdata[7:0];
            next_s.tx_empty = 1'b0;
            if (s.arm_mode_fault_flag) begin
                next_s.mode_fault_flag = 1'b0;
                next_s.arm_mode_fault_flag = 1'b0;
            end
        end
        if (s.dp_write & (s.dp_idx == `SPISF_IDX_CTRL)) begin
            next_s.rx_ie = hwdata[`SPISF_CT_RXIE];
            next_s.master = hwdata[`SPISF_CT_MSTR];
            next_s.cpol = hwdata[`SPISF_CT_CPOL];
            next_s.enable = hwdata[`SPISF_CT_EN];
            next_s.tx_ie = hwdata[`SPISF_CT_TXIE];
        end
        if (s.dp_write & (s.dp_idx == `SPISF_IDX_STAT)) begin
            next_s.err_ie = hwdata[`SPISF_ST_ERROR_IRQ_ENABLE];
            next_s.fault_en = hwdata[`SPISF_ST_FDEN];
            next_s.rate = {hwdata[`SPISF_ST_RATEH], hwdata[`SPISF_ST_RATEL]};
        end

        // Hardware sets come last so they win over a clear in the same cycle
        if (done) begin
            if (s.rx_full & ~data_rd) begin
                next_s.ovr = 1'b1;
            end else begin
                next_s.rxd = rx_word;
                next_s.rx_full = 1'b1;
            end
        end
        if (s.fault_en & s.enable) begin
            if (s.master & ~ss_n_i) begin
                next_s.mode_fault_flag = 1'b1;
            end
            if (~s.master & ss_rise & s.busy) begin
                next_s.mode_fault_flag = 1'b1;
            end
        end

        next_s.rx_irq = next_s.rx_full & next_s.rx_ie;
        next_s.err_irq = (next_s.ovr | next_s.mode_fault_flag) & next_s.err_ie;
        next_s.tx_irq = next_s.tx_empty & next_s.tx_ie;
        next_s.mosi = next_s.shreg[7];
        next_s.pins_oe = next_s.enable & next_s.master;
        next_s.miso_oe = next_s.enable & ~next_s.master & ~ss_n_i;
        // Master without detection leaves the select pin to general I/O
        next_s.ss_owned = next_s.enable & (~next_s.master | next_s.fault_en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.master <= `SPISF_RST_MASTER;
            s.tx_empty <= `SPISF_RST_TXE;
            s.hreadyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = 1'b0;
    assign sclk_o = s.sclk_int;
    assign sclk_oe = s.pins_oe;
    assign mosi_o = s.mosi;
    assign mosi_oe = s.pins_oe;
    assign miso_o = s.mosi;
    assign miso_oe = s.miso_oe;
    assign ss_owned = s.ss_owned;
    assign rx_irq = s.rx_irq;
    assign err_irq = s.err_irq;
    assign tx_irq = s.tx_irq;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_rx_full_set: assert property (done && !s.rx_full |=> s.rx_full && s.rxd == $past(rx_word))
        else $error("receive full not set on completed byte");
    a_rx_irq_level: assert property (s.rx_full && s.rx_ie |-> ##1 (s.rx_irq || !s.rx_full))
        else $error("receive interrupt missing");
    a_rd_clears_full: assert property (data_rd && !done |=> !s.rx_full)
        else $error("data read left receive full set");
    a_err_irq_gate: assert property (!s.err_ie |-> !s.err_irq)
        else $error("error interrupt while disabled");
    a_ovr_keep_old: assert property (done && s.rx_full && !data_rd |=> s.ovr && $stable(s.rxd))
        else $error("overrun not flagged or old byte lost");
    a_ovr_two_step: assert property (data_rd && s.arm_ovr && !done |=> !s.ovr)
        else $error("overrun not cleared by armed data read");
    a_mode_fault_flag_master: assert property (s.enable && s.master && s.fault_en && !ss_n_i |=> s.mode_fault_flag)
        else $error("master mode fault not set");
    a_mode_fault_flag_no_set: assert property (!s.fault_en && !s.mode_fault_flag |=> !s.mode_fault_flag)
        else $error("mode fault set with detection off");
    a_mode_fault_flag_two_step: assert property (data_wr && s.arm_mode_fault_flag && !s.fault_en |=> !s.mode_fault_flag)
        else $error("mode fault not cleared by armed write");
    a_tx_load_two: assert property ($fell(s.tx_empty) && s.enable && !s.busy |-> ##[0:1] s.tx_empty)
        else $error("idle transmit load took over two cycles");
    a_div_two: assert property (pulse && s.rate == 2'b00 && s.busy |=> !pulse)
        else $error("serial clock half period too short");
    a_miso_float: assert property (ss_n_i |=> !miso_oe)
        else $error("deselected slave drives output");

    c_overrun: cover property (done && s.rx_full);
    c_master_byte: cover property (done && s.master);
    c_slave_byte: cover property (done && !s.master);
    c_slave_fault: cover property (s.enable && !s.master && ss_rise && s.busy && s.fault_en);
endmodule

// ==== spisf_peer.sv ====
`timescale 1ns/1ps
// Peer slave on the serial side; cpol 0, samples on rise, shifts on fall
module spisf_peer (
    input wire logic hclk,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic sclk_d = 1'b0;
    logic toggle = 1'b0;
    always @(posedge hclk) begin
        sclk_d <= sclk;
        toggle <= ~toggle;
        if (!sel) begin
            sh <= tx_byte;
        end else if (sclk && !sclk_d) begin
            got <= {got[6:0], mosi};
        end else if (!sclk && sclk_d) begin
            sh <= {sh[6:0], 1'b0};
        end
    end
    // Deselected line changes every cycle so a stale bit cannot pass
    assign miso = sel ? sh[7] : toggle;
endmodule

// ==== spisf_tb_top.sv ====
`timescale 1ns/1ps
module spisf_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, seed = 32'h4239;
    logic hreadyout, hresp, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, miso_w;
    logic ss_owned, rx_irq, err_irq, tx_irq, sclk_q;
    logic ss_n = 1'b1;
    logic sclk_s = 1'b0;
    logic mosi_s = 1'b0;
    logic [7:0] sgot;
    logic peer_sel = 1'b0;
    logic [7:0] peer_tx = 8'h0;
    logic [7:0] peer_got, b0, b1;
    int bad_count = 0, n_tests = 0, cnt = 0, half = 0, falls = 0;
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (sclk_q === 1'b1 && sclk_o === 1'b0) falls++;
        if (sclk_o !== sclk_q) begin
            half = cnt;
            cnt = 1;
        end else cnt++;
        sclk_q = sclk_o;
    end
    spisf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sclk_i(sclk_s), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
        .mosi_i(mosi_s), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .ss_n_i(ss_n), .ss_owned(ss_owned), .rx_irq(rx_irq), .err_irq(err_irq),
        .tx_irq(tx_irq));
    spisf_peer peer (.hclk(hclk), .sclk(sclk_o), .mosi(mosi_o), .sel(peer_sel), .tx_byte(peer_tx),
        .miso(miso_w), .got(peer_got));
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function logic [31:0] bd(input logic [1:0] r);
        return (r == 2'h0) ? 32'h2 : (r == 2'h1) ? 32'h8 : (r == 2'h2) ? 32'h20 : 32'h80;
    endfunction
    task tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
            n++;
            if (n > 50) begin
                bad_count++;
                tally_and_finish;
            end
        end
    endtask
    // Address phase, then data phase; read data taken at the closing edge
    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        wait_rdy;
        rd = hrdata;
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // One master byte; peer reselected first so it reloads its byte
    task xfer(input logic [7:0] tx, input logic [7:0] px);
        int f0, n;
        peer_tx <= px;
        peer_sel <= 1'b0;
        @(posedge hclk);
        @(posedge hclk);
        peer_sel <= 1'b1;
        f0 = falls;
        bus(1'b1, 32'h48, {24'h0, tx});
        n = 0;
        while (falls < f0 + 8) begin
            @(posedge hclk);
            n++;
            if (n > 3000) begin
                bad_count++;
                tally_and_finish;
            end
        end
        repeat (3) @(posedge hclk);
    endtask
    // Bench acts as serial master towards a slave dut, cpol 0; captures the slave output at each rise
    task sbits(input logic [7:0] v, input int nb);
        for (int i = 7; i > 7 - nb; i--) begin
            mosi_s <= v[i];
            repeat (3) @(posedge hclk);
            sgot = {sgot[6:0], miso_o};
            sclk_s <= 1'b1;
            repeat (4) @(posedge hclk);
            sclk_s <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(32'h44, 32'h08);
        rdc(32'h40, 32'h20);
        rdc(32'h80, 32'h0);
        bus(1'b1, 32'h40, 32'h22);
        @(posedge hclk);
        chk({31'h0, ss_owned}, 32'h0);
        $display("reset test done");
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, 32'h44, r);
            rdc(32'h44, 32'h08 | r);
            b0 = rnd();
            b1 = rnd();
            xfer(b0, b1);
            chk(half, bd(r));
            chk({24'h0, peer_got}, {24'h0, b0});
            rdc(32'h44, 32'h88 | r);
            rdc(32'h48, {24'h0, b1});
            rdc(32'h44, 32'h08 | r);
        end
        $display("rate test done");
        bus(1'b1, 32'h40, 32'ha2);
        b0 = rnd();
        b1 = rnd();
        xfer(8'h5a, b0);
        chk({31'h0, rx_irq}, 32'h1);
        xfer(8'ha5, b1);
        chk({31'h0, err_irq}, 32'h0);
        bus(1'b1, 32'h44, 32'h43);
        @(posedge hclk);
        chk({31'h0, err_irq}, 32'h1);
        rdc(32'h48, {24'h0, b0});
        rdc(32'h44, 32'h6b);
        rdc(32'h48, {24'h0, b0});
        rdc(32'h44, 32'h4b);
        $display("overrun test done");
        bus(1'b1, 32'h44, 32'h47);
        @(posedge hclk);
        chk({31'h0, ss_owned}, 32'h1);
        ss_n <= 1'b0;
        repeat (2) @(posedge hclk);
        ss_n <= 1'b1;
        rdc(32'h44, 32'h5f);
        bus(1'b1, 32'h44, 32'h43);
        rdc(32'h44, 32'h5b);
        xfer(rnd(), rnd());
        rdc(32'h44, 32'hcb);
        ss_n <= 1'b0;
        repeat (3) @(posedge hclk);
        ss_n <= 1'b1;
        rdc(32'h44, 32'hcb);
        $display("fault test done");
        bus(1'b0, 32'h48, 32'h0);
        bus(1'b1, 32'h40, 32'h02);
        bus(1'b1, 32'h44, 32'h07);
        b0 = rnd();
        b1 = rnd();
        bus(1'b1, 32'h48, {24'h0, b0});
        ss_n <= 1'b0;
        sbits(b1, 8);
        chk({24'h0, sgot}, {24'h0, b0});
        rdc(32'h48, {24'h0, b1});
        @(posedge hclk);
        chk({31'h0, ss_owned}, 32'h1);
        sbits(b0, 3);
        bus(1'b1, 32'h48, 32'h3c);
        rdc(32'h44, 32'h07);
        ss_n <= 1'b1;
        rdc(32'h44, 32'h17);
        @(posedge hclk);
        chk({31'h0, miso_oe}, 32'h0);
        $display("slave test done");
        tally_and_finish;
    end
endmodule
